// ### rtl/dds_function_generator.sv
/*
  Direct digital synthesis source with lookup memory, staging list,
  linear sweep and sample clock selection, behind an AHB-Lite slave.
  Assumes one AHB-Lite master, word transfers, and a converter that
  takes a sample whenever the valid bit is high.
*/
`timescale 1ns/100ps
`include "dds_defines.svh"
module dds_function_generator import dds_pkg::*; #(
  parameter int ACC_W = 32,
  parameter int ADDR_W = 10,
  parameter int ENTRIES = 16,
  parameter int DIV_W = 16,
  parameter logic [DIV_W-1:0] MAX_DIV = 16'hffff
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [31:0] O_HRDATA,
  input wire logic I_EXT_CLK,
  output dac_s O_DAC
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int IDX_W = $clog2(ENTRIES);

  bus_ap_s ap_ff, nxt_ap;
  logic rd_wait_ff, nxt_rd_wait;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [ACC_W-1:0] ftw_ff, nxt_ftw;
  logic [DIV_W-1:0] div_ff, nxt_div;
  logic [IDX_W-1:0] lidx_ff, nxt_lidx;
  logic [IDX_W:0] llen_ff, nxt_llen;
  logic [ACC_W-1:0] s_start_ff, nxt_s_start, s_end_ff, nxt_s_end;
  logic [ACC_W-1:0] s_steps_ff, nxt_s_steps;
  logic [31:0] s_dur_ff, nxt_s_dur;
  logic [SAMPLE_W-1:0] mem_ff [DEPTH];
  logic [ACC_W-1:0] l_ftw_ff [ENTRIES];
  logic [31:0] l_dur_ff [ENTRIES];
  logic [ADDR_W:0] ld_cnt_ff, nxt_ld_cnt;
  logic valid_ff, nxt_valid, small_ff, nxt_small, quant_ff, nxt_quant;
  seq_state_e state_ff, nxt_state;
  logic [IDX_W-1:0] stage_ff, nxt_stage;
  logic [31:0] dur_cnt_ff, nxt_dur_cnt;
  logic [ACC_W-1:0] cur_ftw_ff, nxt_cur_ftw;
  logic [ACC_W-1:0] quo_ff, nxt_quo, rem_ff, nxt_rem, dsr_ff, nxt_dsr;
  logic [ACC_W-1:0] left_ff, nxt_left;
  logic [ACC_W:0] err_ff, nxt_err;
  logic [7:0] bits_ff, nxt_bits;
  logic dir_ff, nxt_dir;
  logic [ACC_W-1:0] acc_ff, nxt_acc;
  dac_s dac_ff, nxt_dac;

  logic we, tick, play, start;
  logic [1:0] mode;
  logic [ADDR_W-1:0] rd_addr;
  logic [SAMPLE_W-1:0] rd_sample;
  logic [31:0] dur_now, dur_lim;
  logic [ACC_W:0] tmp, nerr;
  logic [ACC_W-1:0] step;

  assign mode = ctrl_ff[`CTRL_MODE +: 2];
  assign we = ap_ff.wr;
  assign O_HREADYOUT = ~(ap_ff.rd & ~rd_wait_ff);
  assign O_HRESP = 1'b0;
  assign O_HRDATA = rdata_ff;
  assign O_DAC = dac_ff;

  // Sample strobe source
  dds_sample_tick #(.DIV_W(DIV_W)) u_tick (
    .i_clk(I_CLK_SYS),
    .i_reset(I_RESET),
    .i_ext_sel(ctrl_ff[`CTRL_EXT]),
    .i_ext_clk(I_EXT_CLK),
    .i_div(div_ff),
    .o_tick(tick)
  );

  // Bus phases: writes take no wait, reads take one wait state
  always_comb begin
    nxt_ap = ap_ff;
    if (I_HREADY) begin
      nxt_ap.wr = I_HSEL & I_HTRANS[1] & I_HWRITE;
      nxt_ap.rd = I_HSEL & I_HTRANS[1] & ~I_HWRITE;
      nxt_ap.addr = I_HADDR[7:0];
    end
    nxt_rd_wait = ap_ff.rd & ~rd_wait_ff;
    nxt_rdata = rdata_ff;
    if (ap_ff.rd & ~rd_wait_ff) begin
      case (ap_ff.addr)
        `OFS_CTRL: nxt_rdata = {24'h0, ctrl_ff};
        `OFS_FTW: nxt_rdata = 32'(ftw_ff);
        `OFS_DIV: nxt_rdata = 32'(div_ff);
        `OFS_STATUS: begin
          nxt_rdata = 32'h0;
          nxt_rdata[`ST_VALID] = valid_ff;
          nxt_rdata[`ST_SMALL] = small_ff;
          nxt_rdata[`ST_QUANT] = quant_ff;
          nxt_rdata[`ST_BUSY] = (state_ff == S_PREP) |
                                (state_ff == S_RUN);
          nxt_rdata[`ST_DONE] = (state_ff == S_DONE);
          nxt_rdata[`ST_STAGE +: IDX_W] = stage_ff;
        end
        `OFS_L_IDX: nxt_rdata = 32'(lidx_ff);
        `OFS_L_LEN: nxt_rdata = 32'(llen_ff);
        `OFS_S_START: nxt_rdata = 32'(s_start_ff);
        `OFS_S_END: nxt_rdata = 32'(s_end_ff);
        `OFS_S_STEPS: nxt_rdata = 32'(s_steps_ff);
        `OFS_S_DUR: nxt_rdata = s_dur_ff;
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  // Configuration registers written by software
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ftw = ftw_ff;
    nxt_div = div_ff;
    nxt_lidx = lidx_ff;
    nxt_llen = llen_ff;
    nxt_s_start = s_start_ff;
    nxt_s_end = s_end_ff;
    nxt_s_steps = s_steps_ff;
    nxt_s_dur = s_dur_ff;
    if (we) begin
      case (ap_ff.addr)
        `OFS_CTRL: nxt_ctrl = I_HWDATA[7:0];
        `OFS_FTW: nxt_ftw = I_HWDATA[ACC_W-1:0];
        `OFS_DIV: begin
          if (I_HWDATA == 32'h0)
            nxt_div = DIV_W'(1);
          else if (I_HWDATA > 32'(MAX_DIV))
            nxt_div = MAX_DIV;
          else
            nxt_div = I_HWDATA[DIV_W-1:0];
        end
        `OFS_L_IDX: nxt_lidx = I_HWDATA[IDX_W-1:0];
        `OFS_L_LEN: nxt_llen = (I_HWDATA > 32'(ENTRIES)) ?
                               (IDX_W+1)'(ENTRIES) :
                               I_HWDATA[IDX_W:0];
        `OFS_S_START: nxt_s_start = I_HWDATA[ACC_W-1:0];
        `OFS_S_END: nxt_s_end = I_HWDATA[ACC_W-1:0];
        `OFS_S_STEPS: nxt_s_steps = I_HWDATA[ACC_W-1:0];
        `OFS_S_DUR: nxt_s_dur = I_HWDATA;
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
  end

  // Waveform load with size checks
  always_comb begin
    nxt_ld_cnt = ld_cnt_ff;
    nxt_valid = valid_ff;
    nxt_small = small_ff;
    nxt_quant = quant_ff;
    if (we && ap_ff.addr == `OFS_LD_START) begin
      nxt_ld_cnt = '0;
      nxt_valid = 1'b0;
      nxt_small = 1'b0;
      nxt_quant = 1'b0;
    end else if (we && ap_ff.addr == `OFS_LD_DATA) begin
      if (ld_cnt_ff < (ADDR_W+1)'(DEPTH))
        nxt_ld_cnt = ld_cnt_ff + 1'b1;
    end else if (we && ap_ff.addr == `OFS_LD_COMMIT) begin
      nxt_small = (ld_cnt_ff < (ADDR_W+1)'(`MIN_WAVE));
      nxt_quant = (ld_cnt_ff % (ADDR_W+1)'(`WAVE_QUANT)) != '0;
      nxt_valid = ~nxt_small & ~nxt_quant;
    end
  end

  // Lookup memory and staging list, one writer per entry
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_mem
      always_ff @(posedge I_CLK_SYS) begin
        if (we && ap_ff.addr == `OFS_LD_DATA &&
            ld_cnt_ff == (ADDR_W+1)'(gi)) begin
          mem_ff[gi] <= I_HWDATA[SAMPLE_W-1:0];
        end
      end
    end
    for (gi = 0; gi < ENTRIES; gi++) begin : g_list
      always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
          l_ftw_ff[gi] <= '0;
          l_dur_ff[gi] <= '0;
        end else if (we && lidx_ff == IDX_W'(gi)) begin
          if (ap_ff.addr == `OFS_L_FTW)
            l_ftw_ff[gi] <= I_HWDATA[ACC_W-1:0];
          if (ap_ff.addr == `OFS_L_DUR)
            l_dur_ff[gi] <= I_HWDATA;
        end
      end
    end
  endgenerate

  // Sequencer: single word, hop list or linear sweep
  assign start = we && ap_ff.addr == `OFS_CTRL &&
                 I_HWDATA[`CTRL_RUN] &&
                 I_HWDATA[`CTRL_MODE +: 2] != `MODE_SINGLE;
  assign dur_now = (mode == `MODE_SWEEP) ? s_dur_ff : l_dur_ff[stage_ff];
  assign dur_lim = (dur_now == 32'h0) ? 32'h1 : dur_now;
  assign tmp = {rem_ff, quo_ff[ACC_W-1]};
  assign nerr = err_ff + {1'b0, rem_ff};
  assign step = quo_ff + ACC_W'(nerr >= {1'b0, dsr_ff});
  always_comb begin
    nxt_state = state_ff;
    nxt_stage = stage_ff;
    nxt_dur_cnt = dur_cnt_ff;
    nxt_cur_ftw = cur_ftw_ff;
    nxt_quo = quo_ff;
    nxt_rem = rem_ff;
    nxt_dsr = dsr_ff;
    nxt_left = left_ff;
    nxt_err = err_ff;
    nxt_bits = bits_ff;
    nxt_dir = dir_ff;
    if (mode == `MODE_SINGLE)
      nxt_cur_ftw = ftw_ff;
    case (state_ff)
      S_IDLE, S_DONE: begin
        if (start) begin
          nxt_stage = '0;
          nxt_dur_cnt = '0;
          nxt_err = '0;
          if (I_HWDATA[`CTRL_MODE +: 2] == `MODE_SWEEP) begin
            nxt_cur_ftw = s_start_ff;
            nxt_dir = s_end_ff < s_start_ff;
            nxt_quo = nxt_dir ? s_start_ff - s_end_ff :
                                s_end_ff - s_start_ff;
            nxt_rem = '0;
            nxt_dsr = (s_steps_ff < ACC_W'(2)) ? ACC_W'(1) :
                                                 s_steps_ff - 1'b1;
            nxt_left = (s_steps_ff < ACC_W'(2)) ? '0 :
                                                  s_steps_ff - 1'b1;
            nxt_bits = 8'(ACC_W - 1);
            nxt_state = S_PREP;
          end else if (llen_ff == '0) begin
            nxt_state = S_DONE;
          end else begin
            nxt_cur_ftw = l_ftw_ff[0];
            nxt_state = S_RUN;
          end
        end
      end
      S_PREP: begin
        // Restoring division gives per-step increment and remainder
        if (tmp >= {1'b0, dsr_ff}) begin
          nxt_rem = ACC_W'(tmp - {1'b0, dsr_ff});
          nxt_quo = {quo_ff[ACC_W-2:0], 1'b1};
        end else begin
          nxt_rem = tmp[ACC_W-1:0];
          nxt_quo = {quo_ff[ACC_W-2:0], 1'b0};
        end
        nxt_bits = bits_ff - 1'b1;
        if (bits_ff == 8'h0)
          nxt_state = S_RUN;
      end
      S_RUN: begin
        if (tick) begin
          if (dur_cnt_ff + 1'b1 >= dur_lim) begin
            nxt_dur_cnt = '0;
            if (mode == `MODE_SWEEP) begin
              if (left_ff == '0) begin
                nxt_state = S_DONE;
              end else begin
                // Spread the remainder so the last step hits the end
                nxt_left = left_ff - 1'b1;
                nxt_err = (nerr >= {1'b0, dsr_ff}) ?
                          nerr - {1'b0, dsr_ff} : nerr;
                nxt_cur_ftw = dir_ff ? cur_ftw_ff - step :
                                       cur_ftw_ff + step;
              end
            end else if (IDX_W'(stage_ff + 1'b1) == '0 ||
                         (IDX_W+1)'(stage_ff) + 1'b1 >= llen_ff) begin
              nxt_state = S_DONE;
            end else begin
              nxt_stage = stage_ff + 1'b1;
              nxt_cur_ftw = l_ftw_ff[nxt_stage];
            end
          end else begin
            nxt_dur_cnt = dur_cnt_ff + 1'b1;
          end
        end
      end
      default: nxt_state = S_IDLE;
    endcase
    if (~ctrl_ff[`CTRL_RUN] && state_ff != S_IDLE && !start)
      nxt_state = S_IDLE;
  end

  // Accumulator and converter sample
  assign play = ctrl_ff[`CTRL_RUN] & ~ctrl_ff[`CTRL_ARB] & valid_ff &
                (state_ff != S_PREP); // Start word lasts one step
  assign rd_addr = acc_ff[ACC_W-1 -: ADDR_W];
  assign rd_sample = mem_ff[rd_addr];
  always_comb begin
    nxt_acc = acc_ff;
    nxt_dac = dac_ff;
    nxt_dac.valid = 1'b0;
    if (tick && play) begin
      nxt_dac.valid = 1'b1;
      nxt_dac.data = rd_sample;
      nxt_acc = acc_ff + cur_ftw_ff;
    end
  end

  // Register every group except the lookup memory and staging list
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      ap_ff <= '0;
      rd_wait_ff <= 1'b0;
      rdata_ff <= '0;
      ctrl_ff <= `CTRL_RST;
      ftw_ff <= '0;
      div_ff <= `DIV_RST;
      lidx_ff <= '0;
      llen_ff <= '0;
      s_start_ff <= '0;
      s_end_ff <= '0;
      s_steps_ff <= '0;
      s_dur_ff <= '0;
      ld_cnt_ff <= '0;
      valid_ff <= 1'b0;
      small_ff <= 1'b0;
      quant_ff <= 1'b0;
      state_ff <= S_IDLE;
      stage_ff <= '0;
      dur_cnt_ff <= '0;
      cur_ftw_ff <= '0;
      quo_ff <= '0;
      rem_ff <= '0;
      dsr_ff <= '0;
      left_ff <= '0;
      err_ff <= '0;
      bits_ff <= '0;
      dir_ff <= 1'b0;
      acc_ff <= '0;
      dac_ff <= '0;
    end else begin
      ap_ff <= nxt_ap;
      rd_wait_ff <= nxt_rd_wait;
      rdata_ff <= nxt_rdata;
      ctrl_ff <= nxt_ctrl;
      ftw_ff <= nxt_ftw;
      div_ff <= nxt_div;
      lidx_ff <= nxt_lidx;
      llen_ff <= nxt_llen;
      s_start_ff <= nxt_s_start;
      s_end_ff <= nxt_s_end;
      s_steps_ff <= nxt_s_steps;
      s_dur_ff <= nxt_s_dur;
      ld_cnt_ff <= nxt_ld_cnt;
      valid_ff <= nxt_valid;
      small_ff <= nxt_small;
      quant_ff <= nxt_quant;
      state_ff <= nxt_state;
      stage_ff <= nxt_stage;
      dur_cnt_ff <= nxt_dur_cnt;
      cur_ftw_ff <= nxt_cur_ftw;
      quo_ff <= nxt_quo;
      rem_ff <= nxt_rem;
      dsr_ff <= nxt_dsr;
      left_ff <= nxt_left;
      err_ff <= nxt_err;
      bits_ff <= nxt_bits;
      dir_ff <= nxt_dir;
      acc_ff <= nxt_acc;
      dac_ff <= nxt_dac;
    end
  end

  // Checks on the synthesis path
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);

  sequence s_play_tick;
    tick && play;
  endsequence
  property p_sample_out;
    s_play_tick |=> O_DAC.valid && O_DAC.data == $past(rd_sample);
  endproperty
  a_sample_out: assert property (p_sample_out)
    else $error("sample not taken from accumulator address");
  property p_acc_add;
    s_play_tick |=> acc_ff == $past(acc_ff) + $past(cur_ftw_ff);
  endproperty
  a_acc_add: assert property (p_acc_add)
    else $error("accumulator did not add tuning word");
  property p_acc_hold;
    !tick |=> $stable(acc_ff) && !O_DAC.valid;
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("accumulator moved without sample tick");
  property p_arb_off;
    ctrl_ff[`CTRL_ARB] |=> !O_DAC.valid;
  endproperty
  a_arb_off: assert property (p_arb_off)
    else $error("lookup output while arbitrary mode set");
  property p_ftw_write;
    we && ap_ff.addr == `OFS_FTW && mode == `MODE_SINGLE &&
    !(nxt_ctrl != ctrl_ff) |=> ##1 cur_ftw_ff == $past(I_HWDATA, 2);
  endproperty
  a_ftw_write: assert property (p_ftw_write)
    else $error("tuning word write did not take effect");
  property p_too_small;
    we && ap_ff.addr == `OFS_LD_COMMIT &&
    ld_cnt_ff < (ADDR_W+1)'(`MIN_WAVE) |=> small_ff && !valid_ff;
  endproperty
  a_too_small: assert property (p_too_small)
    else $error("short waveform accepted");
  property p_quantum;
    we && ap_ff.addr == `OFS_LD_COMMIT &&
    ld_cnt_ff[2:0] != 3'h0 |=> quant_ff && !valid_ff;
  endproperty
  a_quantum: assert property (p_quantum)
    else $error("waveform off quantum accepted");
  property p_div_zero;
    we && ap_ff.addr == `OFS_DIV && I_HWDATA == 32'h0
    |=> div_ff == DIV_W'(1);
  endproperty
  a_div_zero: assert property (p_div_zero)
    else $error("zero divisor not coerced to one");
  sequence s_div3_gap;
    !tick ##1 !tick ##1 tick;
  endsequence
  property p_div_three;
    tick && div_ff == DIV_W'(3) && !ctrl_ff[`CTRL_EXT] && !we &&
    $stable(div_ff) && $stable(ctrl_ff) |=> s_div3_gap;
  endproperty
  a_div_three: assert property (p_div_three)
    else $error("divide-by-three tick spacing wrong");
  property p_ext_edge;
    ctrl_ff[`CTRL_EXT] && $stable(ctrl_ff) && $rose(I_EXT_CLK)
    |=> tick;
  endproperty
  a_ext_edge: assert property (p_ext_edge)
    else $error("external clock edge gave no tick");
  property p_stage_len;
    state_ff == S_RUN |-> dur_cnt_ff < dur_lim;
  endproperty
  a_stage_len: assert property (p_stage_len)
    else $error("stage ran past its duration");
endmodule

// ### rtl/dds_defines.svh
/*
  Register offsets, control fields, reset values and load limits
  of the function generator.
  Assumes byte addresses taken from the low eight address bits.
*/
`ifndef DDS_DEFINES_SVH
`define DDS_DEFINES_SVH
`define OFS_CTRL 8'h00
`define OFS_FTW 8'h04
`define OFS_DIV 8'h08
`define OFS_LD_START 8'h0c
`define OFS_LD_DATA 8'h10
`define OFS_LD_COMMIT 8'h14
`define OFS_STATUS 8'h18
`define OFS_L_IDX 8'h1c
`define OFS_L_FTW 8'h20
`define OFS_L_DUR 8'h24
`define OFS_L_LEN 8'h28
`define OFS_S_START 8'h2c
`define OFS_S_END 8'h30
`define OFS_S_STEPS 8'h34
`define OFS_S_DUR 8'h38
`define CTRL_RUN 0
`define CTRL_EXT 1
`define CTRL_ARB 2
`define CTRL_MODE 4
`define MODE_SINGLE 2'h0
`define MODE_LIST 2'h1
`define MODE_SWEEP 2'h2
`define ST_VALID 0
`define ST_SMALL 1
`define ST_QUANT 2
`define ST_BUSY 3
`define ST_DONE 4
`define ST_STAGE 8
`define CTRL_RST 8'h00
`define DIV_RST 16'h0001
`define MIN_WAVE 256
`define WAVE_QUANT 8
`endif

// ### rtl/dds_pkg.sv
/*
  Types shared by the function generator files.
  Assumes the defines header and the module parameters supply all numeric constants except SAMPLE_W.
*/
package dds_pkg;
  parameter int SAMPLE_W = 16;
  // Sequencer states
  typedef enum {S_IDLE, S_PREP, S_RUN, S_DONE} seq_state_e;
  // One output sample towards the converter
  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] data;
  } dac_s;
  // Captured bus address phase
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
  } bus_ap_s;
endpackage

// ### rtl/dds_sample_tick.sv
/*
  Sample clock strobe: divide-down of the system clock or edges
  of an external clock.
  Assumes i_div is at least one and i_ext_clk is synchronous.
*/
`timescale 1ns/100ps
module dds_sample_tick #(
  parameter int DIV_W = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ext_sel,
  input wire logic i_ext_clk,
  input wire logic [DIV_W-1:0] i_div,
  output logic o_tick
);
  logic [DIV_W-1:0] cnt_ff, nxt_cnt;
  logic ext_prev_ff, nxt_ext_prev;
  logic tick_ff, nxt_tick;

  // Count n timebase cycles per tick, or follow external edges
  always_comb begin
    nxt_ext_prev = i_ext_clk;
    nxt_cnt = cnt_ff + 1'b1;
    nxt_tick = 1'b0;
    if (i_ext_sel) begin
      nxt_cnt = '0;
      nxt_tick = i_ext_clk & ~ext_prev_ff;
    end else if (cnt_ff >= i_div - 1'b1) begin
      nxt_cnt = '0;
      nxt_tick = 1'b1;
    end
  end

  // Register the divider state
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_ff <= '0;
      ext_prev_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      ext_prev_ff <= nxt_ext_prev;
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;
endmodule

// ### tb/dac_sink.sv
/*
  Converter side model: counts samples, their spacing and address steps.
  Assumes samples come as one-cycle valid pulses, data as the address.
*/
`timescale 1ns/100ps
module dac_sink import dds_pkg::*; (
  input wire logic i_clk,
  input wire logic i_clear,
  input wire dac_s i_dac
);
  int count = 0;
  int gap = 0;
  int run_len = 0;
  logic [9:0] prev = 10'h0;
  logic [9:0] steps [16];
  // Take each sample, the cycles since the last one and, for the first 16 steps, the step size
  always @(posedge i_clk) begin
    run_len <= run_len + 1;
    if (i_clear) begin
      count <= 0;
    end else if (i_dac.valid === 1'b1) begin
      if (count > 0 && count < 17) begin
        steps[count-1] <= i_dac.data[9:0] - prev;
      end
      prev <= i_dac.data[9:0];
      gap <= run_len + 1;
      run_len <= 0;
      count <= count + 1;
    end
  end
endmodule

// ### tb/test_dds_function_generator.sv
/*
  Self-checking bench of the function generator.
  Assumes the converter model dac_sink and one AHB-Lite master here.
*/
`timescale 1ns/100ps
`include "dds_defines.svh"
module test_dds_function_generator import dds_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ext_clk = 1'b0;
  logic clr = 1'b0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd_q;
  logic [31:0] q;
  dac_s dac;
  int errors = 0;
  int compares = 0;
  // 100 MHz system clock
  always #5 clk = ~clk;
  dds_function_generator dut (.I_CLK_SYS(clk), .I_RESET(rst),
    .I_HSEL(1'b1), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .O_HRDATA(hrdata),
    .I_EXT_CLK(ext_clk), .O_DAC(dac));
  dac_sink sink (.i_clk(clk), .i_clear(clr), .i_dac(dac));
  task automatic tally_and_finish();
    $display("Mismatches %0d, comparisons %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Sample ready at each rising edge; return at the edge that takes it
  task automatic bus_wait();
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      rd_q = hrdata;
      if (hready === 1'b1) break;
    end
    if (k == 20) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    bus_wait();
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
    r = rd_q;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask
  task automatic clear();
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  // Bounded wait for a number of samples since the last clear
  task automatic wait_n(input int n);
    int k;
    for (k = 0; k < 5000 && sink.count < n; k++) @(negedge clk);
    if (k == 5000) begin
      errors++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask
  task automatic load(input int n, output logic [31:0] r);
    wr(`OFS_LD_START, 32'h0);
    for (int i = 0; i < n; i++) wr(`OFS_LD_DATA, i);
    wr(`OFS_LD_COMMIT, 32'h0);
    rd(`OFS_STATUS, r);
  endtask
  task automatic t_regs();
    wr(`OFS_FTW, 32'h1234_5678);
    wr(8'h3c, 32'hffff_ffff);
    rd(`OFS_FTW, q);
    check(q, 32'h1234_5678);
    rd(8'h3c, q);
    check(q, 32'h0);
    check(hresp, 1'b0);
    $display("Test registers done");
  endtask
  task automatic t_load();
    load(248, q);
    check(q & 32'h7, 32'h2);
    load(257, q);
    check(q & 32'h7, 32'h4);
    load(1024, q);
    check(q & 32'h7, 32'h1);
    $display("Test load done");
  endtask
  task automatic t_single();
    wr(`OFS_DIV, 32'h3);
    wr(`OFS_FTW, 32'h4000_0000);
    wr(`OFS_CTRL, 32'h1);
    clear();
    wait_n(6);
    check(sink.gap, 3);
    for (int i = 0; i < 5; i++) check(sink.steps[i], 256);
    wr(`OFS_FTW, 32'h00c0_0000);
    clear();
    wait_n(2);
    clear();
    wait_n(4);
    check(sink.steps[2], 3);
    check(sink.gap, 3);
    wr(`OFS_DIV, 32'h0);
    clear();
    wait_n(2);
    clear();
    wait_n(3);
    check(sink.gap, 1);
    $display("Test single done");
  endtask
  task automatic t_hop();
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_L_IDX, 32'h0);
    wr(`OFS_L_FTW, 32'h0080_0000);
    wr(`OFS_L_DUR, 32'h3);
    wr(`OFS_L_IDX, 32'h1);
    wr(`OFS_L_FTW, 32'h0140_0000);
    wr(`OFS_L_DUR, 32'h2);
    wr(`OFS_L_LEN, 32'h2);
    clear();
    wr(`OFS_CTRL, 32'h11);
    wait_n(9);
    for (int i = 0; i < 8; i++) check(sink.steps[i], i < 3 ? 2 : 5);
    rd(`OFS_STATUS, q);
    check(q[4], 1'b1);
    $display("Test hop done");
  endtask
  task automatic t_sweep();
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_S_START, 32'h0040_0000);
    wr(`OFS_S_END, 32'h0100_0000);
    wr(`OFS_S_STEPS, 32'h4);
    wr(`OFS_S_DUR, 32'h2);
    clear();
    wr(`OFS_CTRL, 32'h21);
    wait_n(10);
    for (int i = 0; i < 9; i++) check(sink.steps[i], i < 8 ? i / 2 + 1 : 4);
    $display("Test sweep done");
  endtask
  task automatic t_ext();
    wr(`OFS_CTRL, 32'h0);
    clear();
    wr(`OFS_CTRL, 32'h3);
    for (int i = 0; i < 8; i++) begin
      ext_clk <= 1'b1;
      repeat (7) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (7) @(posedge clk);
    end
    check(sink.count > 5, 1);
    check(sink.gap, 14);
    $display("Test external clock done");
  endtask
  task automatic t_arb();
    wr(`OFS_CTRL, 32'h5);
    clear();
    repeat (60) @(posedge clk);
    check(sink.count, 0);
    $display("Test arbitrary mode done");
  endtask
  // Reset, then the scenarios in order
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_load();
    t_single();
    t_hop();
    t_sweep();
    t_ext();
    t_arb();
    tally_and_finish();
  end
endmodule
